// ### core/xst_pkg.sv
// constants for the crystal start-up timeout block
package xst_pkg;
  localparam logic [7:0] XST_CFG_ADDR = 8'h00;
  localparam logic [7:0] XST_STAT_ADDR = 8'h04;
  localparam logic [7:0] XST_IRQ_ADDR = 8'h08;
  localparam logic [7:0] XST_MASK_ADDR = 8'h0C;
  localparam logic [7:0] XST_CTRL_ADDR = 8'h10;
  localparam int XST_KEEP_BIT = 0;
  localparam int XST_SPARE_BIT = 1;
  localparam int XST_PO_LSB = 2;
  localparam int XST_CAL_LSB = 4;
  localparam logic [7:0] XST_CFG_RESET = 8'h04;
  localparam logic [7:0] XST_CFG_WMASK = 8'h3F;
  localparam logic [1:0] XST_CAL_NEVER = 2'h0;
  localparam logic [1:0] XST_CAL_FROM_IDLE = 2'h1;
  localparam logic [1:0] XST_CAL_TO_IDLE = 2'h2;
  localparam logic [1:0] XST_CAL_FOURTH = 2'h3;
  localparam int XST_RIPPLE_W = 6;
  localparam int XST_EXP_W = 9;
  localparam logic [8:0] XST_EXP_0 = 9'h001;
  localparam logic [8:0] XST_EXP_1 = 9'h010;
  localparam logic [8:0] XST_EXP_2 = 9'h040;
  localparam logic [8:0] XST_EXP_3 = 9'h100;
  localparam int XST_IRQ_READY = 0;
  localparam int XST_IRQ_CAL = 1;
  localparam int XST_IRQ_W = 2;
  typedef enum logic [1:0] {
    XST_OFF = 2'b00,
    XST_SETTLE = 2'b01,
    XST_COUNT = 2'b10,
    XST_READY = 2'b11
  } xst_state_t;
endpackage : xst_pkg

// ### core/xst_ripple.sv
// six-bit ripple counter that pulses once per wrap
`timescale 1ns/1ns
module xst_ripple
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic run,
  // expiry
  output logic expire
);
  import xst_pkg::*;
  logic [XST_RIPPLE_W-1:0] cnt_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (!run)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  assign expire = run && (&cnt_q);
endmodule : xst_ripple

// ### core/xst_timeout.sv
// crystal start-up timeout, sleep keep-on and auto calibration control
// Summary of operation
// - setting 3 calibrates on every fourth automatic return to idle
// - chip ready goes low after programmed ripple expiries once crystal settles
// - delay select 0..3 means 1, 16, 64, 256 expiries
// - counter runs on the crystal clock so delay scales with crystal
// - settled flag and chip ready assert in the same cycle
// - keep-running bit holds crystal on during sleep
// - setting 2 calibrates on every automatic return to idle
`timescale 1ns/1ns
module xst_timeout
(
  // clock and reset; clock is the crystal clock
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // radio state machine
  input wire logic crystal_settled_in,
  input wire logic sleep_req,
  input wire logic idle_to_active,
  input wire logic auto_return_idle,
  input wire logic manual_calibrate_strobe,
  output logic crystal_oscillator_en,
  output logic crystal_settled_flag,
  output logic chip_ready_low,
  output logic synth_cal_start,
  // interrupt
  output logic irq
);
  import xst_pkg::*;

  logic [7:0] cfg_q;
  xst_state_t state_q;
  logic [XST_EXP_W-1:0] exp_cnt_q;
  logic [1:0] ret_cnt_q;
  logic [XST_IRQ_W-1:0] irq_q;
  logic [XST_IRQ_W-1:0] mask_q;
  logic ready_q;
  logic ready_d;
  logic cal_q;
  logic expire;
  logic wr;
  logic rd;
  logic [1:0] po_sel;
  logic [1:0] cal_sel;
  logic cal_now;
  logic [XST_IRQ_W-1:0] irq_set;

  function automatic logic [XST_EXP_W-1:0] expire_target(input logic [1:0] sel);
    unique case (sel)
      2'h0: expire_target = XST_EXP_0;
      2'h1: expire_target = XST_EXP_1;
      2'h2: expire_target = XST_EXP_2;
      2'h3: expire_target = XST_EXP_3;
    endcase
  endfunction : expire_target

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign po_sel = cfg_q[XST_PO_LSB +: 2];
  assign cal_sel = cfg_q[XST_CAL_LSB +: 2];

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cfg_q <= XST_CFG_RESET;
    else if (wr && paddr == XST_CFG_ADDR)
      cfg_q <= pwdata[7:0] & XST_CFG_WMASK;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mask_q <= '0;
    else if (wr && paddr == XST_MASK_ADDR)
      mask_q <= pwdata[XST_IRQ_W-1:0];
  end

  // ripple runs only while counting, from the crystal clock itself
  xst_ripple u_ripple
  (
    .clock(clock),
    .rst_n(rst_n),
    .run(state_q == XST_COUNT),
    .expire(expire)
  );

  // sleep drops the crystal unless keep-running is set
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= XST_OFF;
      exp_cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        XST_OFF:
        begin
          if (!sleep_req)
            state_q <= XST_SETTLE;
        end
        XST_SETTLE:
        begin
          exp_cnt_q <= '0;
          if (sleep_req && !cfg_q[XST_KEEP_BIT])
            state_q <= XST_OFF;
          else if (crystal_settled_in)
            state_q <= XST_COUNT;
        end
        XST_COUNT:
        begin
          if (sleep_req && !cfg_q[XST_KEEP_BIT])
            state_q <= XST_OFF;
          else if (expire)
          begin
            exp_cnt_q <= exp_cnt_q + 1'b1;
            // a target lowered mid count ends the wait at the next expiry, not after a wrap
            if (exp_cnt_q + 1'b1 >= expire_target(po_sel))
              state_q <= XST_READY;
          end
        end
        XST_READY:
        begin
          // keep-on in sleep leaves the crystal stable and ready
          if (sleep_req && !cfg_q[XST_KEEP_BIT])
            state_q <= XST_OFF;
        end
      endcase
    end
  end

  assign crystal_oscillator_en = (state_q != XST_OFF);

  // ready drops on the same edge the crystal stops, never after it
  assign ready_d = (state_q == XST_READY) && !(sleep_req && !cfg_q[XST_KEEP_BIT]);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ready_q <= 1'b0;
    else
      ready_q <= ready_d;
  end

  // both indications from one flop so they can never skew
  assign crystal_settled_flag = ready_q;
  assign chip_ready_low = !ready_q;

  always_comb
  begin
    cal_now = 1'b0;
    unique case (cal_sel)
      XST_CAL_NEVER: cal_now = 1'b0;
      XST_CAL_FROM_IDLE: cal_now = idle_to_active;
      XST_CAL_TO_IDLE: cal_now = auto_return_idle;
      XST_CAL_FOURTH: cal_now = auto_return_idle && (ret_cnt_q == 2'h3);
    endcase
    cal_now = cal_now || manual_calibrate_strobe;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ret_cnt_q <= '0;
    else if (cal_sel == XST_CAL_FOURTH && auto_return_idle)
      ret_cnt_q <= ret_cnt_q + 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cal_q <= 1'b0;
    else
      cal_q <= cal_now;
  end

  assign synth_cal_start = cal_q;

  assign irq_set[XST_IRQ_READY] = ready_d && !ready_q;
  assign irq_set[XST_IRQ_CAL] = cal_now;

  // set beats the read-clear in the same cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_q <= '0;
    else if (rd && paddr == XST_IRQ_ADDR)
      irq_q <= irq_set;
    else
      irq_q <= irq_q | irq_set;
  end

  assign irq = |(irq_q & mask_q);

  always_comb
  begin
    prdata = '0;
    pslverr = 1'b0;
    unique case (paddr)
      XST_CFG_ADDR: prdata[7:0] = cfg_q;
      XST_STAT_ADDR: prdata = {28'h0000000, ready_q, crystal_oscillator_en, state_q};
      XST_IRQ_ADDR: prdata[XST_IRQ_W-1:0] = irq_q;
      XST_MASK_ADDR: prdata[XST_IRQ_W-1:0] = mask_q;
      XST_CTRL_ADDR: prdata[XST_EXP_W-1:0] = exp_cnt_q;
      default: pslverr = psel && penable;
    endcase
  end
endmodule : xst_timeout

// ### verification/tb_xst_timeout.sv
// self-checking bench for the crystal start-up timeout block
`timescale 1ns/1ns
module tb_xst_timeout;
  import xst_pkg::*;
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic crystal_settled_in = 0, sleep_req = 0, idle_to_active = 0, auto_return_idle = 0;
  logic manual_calibrate_strobe = 0, crystal_oscillator_en, crystal_settled_flag;
  logic chip_ready_low, synth_cal_start, irq;
  int mismatches = 0, n_tests = 0, cyc = 0, cal_n = 0;
  xst_timeout xst_timeout_i (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .crystal_settled_in, .sleep_req, .idle_to_active,
    .auto_return_idle, .manual_calibrate_strobe, .crystal_oscillator_en,
    .crystal_settled_flag, .chip_ready_low, .synth_cal_start, .irq);
  initial forever #50 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (synth_cal_start === 1'h1) cal_n++;
    if (cyc == 40000)
    begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      $display("mismatch %s exp %h got %h", n, e, s);
      mismatches++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1) @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic pulse(input int k, input logic [7:0] cfg, input int e, input int src);
    apb(1'h1, XST_CFG_ADDR, {24'h0, cfg});
    apb(1'h0, XST_IRQ_ADDR, 32'h0);
    cal_n = 0;
    repeat (k)
    begin
      @(posedge clock);
      auto_return_idle <= (src == 0);
      idle_to_active <= (src == 1);
      manual_calibrate_strobe <= (src == 2);
      @(posedge clock);
      auto_return_idle <= 1'h0;
      idle_to_active <= 1'h0;
      manual_calibrate_strobe <= 1'h0;
    end
    repeat (3) @(posedge clock);
    chk("cal count", e, cal_n);
    chk("irq masked", 0, irq);
    apb(1'h0, XST_IRQ_ADDR, 32'h0);
    chk("irq cal bit", e != 0, rd[XST_IRQ_CAL]);
  endtask : pulse
  task automatic t_timeout;
    int n;
    int e[4] = '{1, 16, 64, 256};
    apb(1'h1, XST_MASK_ADDR, 32'h1);
    apb(1'h0, XST_MASK_ADDR, 32'h0);
    chk("mask", 1, rd);
    for (int s = 0; s < 4; s++)
    begin
      sleep_req <= 1'h1;
      apb(1'h1, XST_CFG_ADDR, 32'(s * 4));
      crystal_settled_in <= 1'h0;
      apb(1'h0, XST_IRQ_ADDR, 32'h0);
      sleep_req <= 1'h0;
      crystal_settled_in <= 1'h1;
      n = 0;
      @(posedge clock);
      while (chip_ready_low === 1'h1 && n < 20000)
      begin
        @(posedge clock);
        n++;
      end
      chk("ready delay", 1, n >= 64 * e[s] && n <= 64 * e[s] + 4);
      chk("settled flag", 1, crystal_settled_flag);
      @(posedge clock);
      chk("irq", 1, irq);
      apb(1'h0, XST_IRQ_ADDR, 32'h0);
      chk("irq ready bit", 1, rd[0]);
      @(posedge clock);
      chk("irq cleared", 0, irq);
      apb(1'h0, XST_STAT_ADDR, 32'h0);
      chk("status", 32'hF, rd);
      apb(1'h0, XST_CTRL_ADDR, 32'h0);
      chk("expiry count", e[s], rd);
    end
    $display("test timeout done");
  endtask : t_timeout
  initial
  begin
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    apb(1'h0, XST_CFG_ADDR, 32'h0);
    chk("cfg reset", 32'(XST_CFG_RESET), rd);
    apb(1'h0, 8'hFC, 32'h0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    t_timeout();
    apb(1'h1, XST_CFG_ADDR, 32'h9);
    sleep_req <= 1'h1;
    repeat (4) @(posedge clock);
    chk("osc keep", 1, crystal_oscillator_en);
    chk("ready kept", 0, chip_ready_low);
    apb(1'h1, XST_CFG_ADDR, 32'h8);
    repeat (4) @(posedge clock);
    chk("osc off", 0, crystal_oscillator_en);
    chk("ready off", 1, chip_ready_low);
    $display("test keep done");
    // crystal held off so no ready event lands inside the calibration checks
    pulse(8, 8'h30, 2, 0);
    pulse(4, 8'h20, 4, 0);
    pulse(2, 8'h00, 0, 0);
    pulse(3, 8'h10, 3, 1);
    pulse(2, 8'h10, 0, 0);
    pulse(3, 8'h00, 3, 2);
    sleep_req <= 1'h0;
    $display("test cal done");
    summarize();
  end
endmodule : tb_xst_timeout
bind xst_timeout xst_timeout_chk xst_timeout_chk_i (.clock, .rst_n, .psel, .penable,
  .pready, .pslverr, .crystal_settled_in, .sleep_req, .idle_to_active, .auto_return_idle,
  .manual_calibrate_strobe, .crystal_oscillator_en, .crystal_settled_flag,
  .chip_ready_low, .synth_cal_start);

// ### verification/xst_timeout_assertions.sv
// port checker for the crystal start-up timeout block
`timescale 1ns/1ns
module xst_timeout_chk
(
  // watched ports
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic crystal_settled_in,
  input wire logic sleep_req,
  input wire logic idle_to_active,
  input wire logic auto_return_idle,
  input wire logic manual_calibrate_strobe,
  input wire logic crystal_oscillator_en,
  input wire logic crystal_settled_flag,
  input wire logic chip_ready_low,
  input wire logic synth_cal_start
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  same_cycle_a: assert property (crystal_settled_flag == !chip_ready_low)
    else $error("settled flag and ready differ");
  osc_first_a: assert property (!crystal_oscillator_en |-> chip_ready_low)
    else $error("ready without oscillator");
  ready_cause_a: assert property ($fell(chip_ready_low) |-> crystal_settled_in)
    else $error("ready before settle");
  ready_delay_a: assert property ($fell(chip_ready_low) |-> $past(crystal_settled_in, 64))
    else $error("ready before one expiry");
  ready_stay_a: assert property (!chip_ready_low && !sleep_req |=> !chip_ready_low)
    else $error("ready dropped while awake");
  cal_cause_a: assert property (synth_cal_start |-> $past(auto_return_idle)
    || $past(idle_to_active) || $past(manual_calibrate_strobe)) else $error("stray cal");
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("apb wait");
  apb_err_a: assert property (pslverr |-> psel && penable)
    else $error("stray slverr");
endmodule : xst_timeout_chk
